// File: lcsc_defs.svh
/*
 Constants of the charger state control: register offsets, reset values,
 timing figures and state codes. Included by the package and the charger control.
*/
// Function
// - Input limit code decodes to milliamps
// - Input voltage loop engage flags input-control
// - Input limiter engage flags input-control
// - System loop status; each change flags
// - Die temperature status; each change flags
// - State code shown; each change flags
// - Off when input invalid, disabled, fresh
// - Invalid input keeps battery connected
// - Fresh battery waits below restart level
// - Restart enable only gates off-to-prequal
// - Prequalification over thirty minutes faults
// - Prequal current and threshold configurable
// - Above prequal threshold enter constant current
// - Regulation reached to CV, then top-off
// - Fast timer starts entering CC, expiry faults
// - Fast timer pauses, suspension bit shown
// - Top-off timer expiry enters done
// - Done restarts CC below restart level
// - Prequal fault: no current, exit by toggle
// - Fast timer fault: same, exit by toggle
// - Input debounce 120ms; quality change flags
`ifndef LCSC_DEFS_SVH
`define LCSC_DEFS_SVH

`define LCSC_ADDR_CFG_A 4'h0
`define LCSC_ADDR_CFG_B 4'h1
`define LCSC_ADDR_CFG_C 4'h2
`define LCSC_ADDR_STAT 4'h3
`define LCSC_ADDR_FLAGS 4'h4
`define LCSC_ADDR_MASK 4'h5
`define LCSC_ADDR_LIMIT 4'h6

`define LCSC_CFG_A_RST 8'h03
`define LCSC_CFG_B_RST 17'h05000
`define LCSC_CFG_C_RST 9'h000
`define LCSC_MASK_RST 5'h1f

`define LCSC_CLK_PERIOD_NS 4
`define LCSC_MS_NS 1000000
`define LCSC_MS_PER_MIN 60000
`define LCSC_MIN_PER_HR 60
`define LCSC_DEBOUNCE_MS 7'd120
`define LCSC_PQ_MIN 5'd30
`define LCSC_FC_BASE_HR 3
`define LCSC_FC_STEP_HR 2
`define LCSC_TOPOFF_STEP_MIN 5

`define LCSC_LIM_SEL_MAX 3'h4
`define LCSC_LIM_MA_STEP 9'd95

`define LCSC_CODE_OFF 4'h0
`define LCSC_CODE_PQ 4'h1
`define LCSC_CODE_CC 4'h2
`define LCSC_CODE_CV 4'h3
`define LCSC_CODE_TOP 4'h4
`define LCSC_CODE_DONE 4'h5
`define LCSC_CODE_PQF 4'h6
`define LCSC_CODE_FCF 4'h7

`endif

// File: lcsc_pkg.sv
/*
 Types of the charger state control: states, register layouts, sense and
 drive carriers. Assumes lcsc_defs.svh is found on the include path.
*/
`default_nettype none
`include "lcsc_defs.svh"
package lcsc_pkg;

	typedef enum logic [7:0] {
		ST_OFF = 8'h01,
		ST_PQ = 8'h02,
		ST_CC = 8'h04,
		ST_CV = 8'h08,
		ST_TOP = 8'h10,
		ST_DONE = 8'h20,
		ST_PQF = 8'h40,
		ST_FCF = 8'h80
	} lcsc_state_t;

	typedef struct packed {
		logic [2:0] inputMinVoltageSel;
		logic [2:0] inputLimitSel;
		logic restartThresholdEnable;
		logic chargeEnableBit;
	} lcsc_cfg_a_t;

	typedef struct packed {
		logic [2:0] finishTimerSel;
		logic [1:0] fastTimerSel;
		logic [5:0] regulationVoltageSel;
		logic [5:0] fastCurrentSel;
	} lcsc_cfg_b_t;

	typedef struct packed {
		logic [2:0] dieTempLimitSel;
		logic [1:0] termCurrentSel;
		logic prechargeCurrentSel;
		logic [2:0] prechargeVoltageSel;
	} lcsc_cfg_c_t;

	typedef struct packed {
		logic inputDebounced;
		logic fastTimerSuspended;
		logic dieTempLoopActive;
		logic systemLoopActive;
		logic inputLimitActive;
		logic inputVoltageLoopActive;
		logic [1:0] inputQualityCode;
		logic [3:0] chargerStateCode;
	} lcsc_stat_t;

	typedef struct packed {
		logic inputQualityIrq;
		logic chargerStateIrq;
		logic dieTempIrq;
		logic systemLoopIrq;
		logic inputControlIrq;
	} lcsc_flags_t;

	typedef struct packed {
		logic inputValid;
		logic [1:0] inputQualityCode;
		logic battBelowPrechargeThreshold;
		logic battAtRegulation;
		logic battBelowRestart;
		logic currentBelowTerm;
		logic ccCurrentBelowFifth;
		logic supplementMode;
		logic battTempFault;
		logic inputVoltageLoop;
		logic inputLimitLoop;
		logic systemLoop;
		logic dieTempLoop;
	} lcsc_sense_t;

	typedef struct packed {
		logic systemRegulate;
		logic batteryConnect;
		logic chargeCurrentOn;
		logic prechargeMode;
		logic constVoltageMode;
	} lcsc_drive_t;

endpackage : lcsc_pkg
`default_nettype wire

// File: lcsc_divider.sv
/*
 Rate divider: one-cycle tick every DIV enabled cycles.
 Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lcsc_divider
	import lcsc_pkg::*;
#(
	parameter int unsigned DIV = 250000
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic enable,
	output logic tick
);

	localparam int unsigned CW = $clog2(DIV + 1);

	logic [CW-1:0] countQ;
	logic [CW-1:0] countD;
	logic tickD;

	always_comb
	begin
		countD = countQ;
		tickD = 1'b0;
		if (enable)
		begin
			if (countQ == CW'(DIV - 1))
			begin
				countD = '0;
				tickD = 1'b1;
			end
			else
				countD = countQ + 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			countQ <= '0;
			tick <= 1'b0;
		end
		else
		begin
			countQ <= countD;
			tick <= tickD;
		end
	end

endmodule : lcsc_divider
`default_nettype wire

// File: lcsc_charger_ctrl.sv
/*
 Charger state control: charge sequencing, prequal/fast/top-off timers,
 input debounce, loop status and change flags, software register port.
 Assumes analog sense inputs are already synchronous to clk_sys.
*/
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_defs.svh"
module lcsc_charger_ctrl
	import lcsc_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `LCSC_MS_NS / `LCSC_CLK_PERIOD_NS,
	parameter int unsigned MS_PER_MIN = `LCSC_MS_PER_MIN,
	parameter bit LIMIT_LOW_DEFAULT = 1'b0
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire lcsc_sense_t sense,
	output lcsc_drive_t drive,
	output lcsc_cfg_a_t cfgA,
	output lcsc_cfg_b_t cfgB,
	output lcsc_cfg_c_t cfgC,
	output lcsc_stat_t status,
	output logic [8:0] inputLimitMa,
	output logic irq
);

	function automatic logic [3:0] state_code(input lcsc_state_t s);
		case (s)
			ST_OFF: state_code = `LCSC_CODE_OFF;
			ST_PQ: state_code = `LCSC_CODE_PQ;
			ST_CC: state_code = `LCSC_CODE_CC;
			ST_CV: state_code = `LCSC_CODE_CV;
			ST_TOP: state_code = `LCSC_CODE_TOP;
			ST_DONE: state_code = `LCSC_CODE_DONE;
			ST_PQF: state_code = `LCSC_CODE_PQF;
			ST_FCF: state_code = `LCSC_CODE_FCF;
			default: state_code = `LCSC_CODE_OFF;
		endcase
	endfunction : state_code

	// Codes 4..7 share the extreme step; low variant mirrors the table
	function automatic logic [8:0] limit_ma(input logic [2:0] sel, input bit lowDefault);
		logic [2:0] step;
		step = (sel >= `LCSC_LIM_SEL_MAX) ? `LCSC_LIM_SEL_MAX : sel;
		if (lowDefault)
			limit_ma = 9'(step + 3'h1) * `LCSC_LIM_MA_STEP;
		else
			limit_ma = 9'(`LCSC_LIM_SEL_MAX - step + 3'h1) * `LCSC_LIM_MA_STEP;
	endfunction : limit_ma

	function automatic logic [8:0] fast_limit_min(input logic [1:0] sel);
		if (sel == 2'h0)
			fast_limit_min = 9'h000;
		else
			fast_limit_min = 9'((`LCSC_FC_BASE_HR + `LCSC_FC_STEP_HR * (int'(sel) - 1)) * `LCSC_MIN_PER_HR);
	endfunction : fast_limit_min

	logic msTick;
	logic minTick;

	lcsc_divider #(.DIV(MS_CYCLES)) msDiv (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.enable(1'b1),
		.tick(msTick)
	);

	lcsc_divider #(.DIV(MS_PER_MIN)) minDiv (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.enable(msTick),
		.tick(minTick)
	);

	// Register port
	lcsc_cfg_a_t cfgAD;
	lcsc_cfg_b_t cfgBD;
	lcsc_cfg_c_t cfgCD;
	lcsc_flags_t flagsQ;
	lcsc_flags_t flagsD;
	lcsc_flags_t maskQ;
	lcsc_flags_t maskD;
	lcsc_flags_t flagSet;
	logic [31:0] rdataD;

	always_comb
	begin
		cfgAD = cfgA;
		cfgBD = cfgB;
		cfgCD = cfgC;
		maskD = maskQ;
		rdataD = 32'h0000_0000;
		if (regWrite)
		begin
			case (regAddr)
				`LCSC_ADDR_CFG_A: cfgAD = lcsc_cfg_a_t'(regWdata[$bits(lcsc_cfg_a_t)-1:0]);
				`LCSC_ADDR_CFG_B: cfgBD = lcsc_cfg_b_t'(regWdata[$bits(lcsc_cfg_b_t)-1:0]);
				`LCSC_ADDR_CFG_C: cfgCD = lcsc_cfg_c_t'(regWdata[$bits(lcsc_cfg_c_t)-1:0]);
				`LCSC_ADDR_MASK: maskD = lcsc_flags_t'(regWdata[$bits(lcsc_flags_t)-1:0]);
				default: ;
			endcase
		end
		if (regRead)
		begin
			case (regAddr)
				`LCSC_ADDR_CFG_A: rdataD = 32'(cfgA);
				`LCSC_ADDR_CFG_B: rdataD = 32'(cfgB);
				`LCSC_ADDR_CFG_C: rdataD = 32'(cfgC);
				`LCSC_ADDR_STAT: rdataD = 32'(status);
				`LCSC_ADDR_FLAGS: rdataD = 32'(flagsQ);
				`LCSC_ADDR_MASK: rdataD = 32'(maskQ);
				`LCSC_ADDR_LIMIT: rdataD = 32'(inputLimitMa);
				default: rdataD = 32'h0000_0000;
			endcase
		end
	end

	// Flags: write one to clear; a set in the same cycle wins
	always_comb
	begin
		flagsD = flagsQ;
		if (regWrite && regAddr == `LCSC_ADDR_FLAGS)
			flagsD = flagsQ & ~lcsc_flags_t'(regWdata[$bits(lcsc_flags_t)-1:0]);
		flagsD = flagsD | flagSet;
	end

	// Input debounce
	logic [6:0] debQ;
	logic [6:0] debD;
	logic inputOk;

	assign inputOk = (debQ == `LCSC_DEBOUNCE_MS);

	always_comb
	begin
		debD = debQ;
		if (!sense.inputValid)
			debD = 7'h00;
		else if (msTick && !inputOk)
			debD = debQ + 7'h01;
	end

	// Charger sequencing
	lcsc_state_t stateQ;
	lcsc_state_t stateD;
	logic [4:0] pqMinQ;
	logic [4:0] pqMinD;
	logic [8:0] fcMinQ;
	logic [8:0] fcMinD;
	logic [5:0] topMinQ;
	logic [5:0] topMinD;
	logic fresh;
	logic inFast;
	logic fcSuspend;
	logic pqExpired;
	logic fcExpired;
	logic topExpired;
	logic [8:0] fcLimit;

	assign inFast = (stateQ == ST_CC) || (stateQ == ST_CV);
	assign fcLimit = fast_limit_min(cfgB.fastTimerSel);
	assign fresh = cfgA.restartThresholdEnable && !sense.battBelowRestart;
	assign pqExpired = (pqMinQ >= `LCSC_PQ_MIN);
	assign fcExpired = (fcLimit != 9'h000) && (fcMinQ >= fcLimit);
	assign topExpired = (topMinQ >= 6'(int'(cfgB.finishTimerSel) * `LCSC_TOPOFF_STEP_MIN));
	assign fcSuspend = inFast && ((stateQ == ST_CC && sense.ccCurrentBelowFifth) || sense.supplementMode
		|| sense.battTempFault);

	always_comb
	begin
		stateD = stateQ;
		// Invalid, undebounced or disabled forces off
		if (!sense.inputValid || !inputOk || !cfgA.chargeEnableBit)
			stateD = ST_OFF;
		else
		begin
			case (stateQ)
				ST_OFF: if (!fresh) stateD = ST_PQ;
				ST_PQ:
				begin
					if (!sense.battBelowPrechargeThreshold)
						stateD = ST_CC;
					else if (pqExpired)
						stateD = ST_PQF;
				end
				ST_CC:
				begin
					if (fcExpired)
						stateD = ST_FCF;
					else if (sense.battAtRegulation)
						stateD = ST_CV;
				end
				ST_CV:
				begin
					if (fcExpired)
						stateD = ST_FCF;
					else if (sense.currentBelowTerm)
						stateD = ST_TOP;
				end
				ST_TOP: if (topExpired) stateD = ST_DONE;
				ST_DONE: if (sense.battBelowRestart) stateD = ST_CC;
				// Held until enable or input drops
				ST_PQF: stateD = ST_PQF;
				// Held until enable or input drops
				ST_FCF: stateD = ST_FCF;
				default: stateD = ST_OFF;
			endcase
		end
	end

	// Timers count minutes; battery temperature fault pauses all of them
	always_comb
	begin
		pqMinD = pqMinQ;
		fcMinD = fcMinQ;
		topMinD = topMinQ;
		if (stateQ != ST_PQ)
			pqMinD = 5'h00;
		else if (minTick && !sense.battTempFault && !pqExpired)
			pqMinD = pqMinQ + 5'h01;
		// Start on entry from non-fast state
		if (stateD == ST_CC && !inFast)
			fcMinD = 9'h000;
		else if (inFast && minTick && !fcSuspend && !fcExpired)
			fcMinD = fcMinQ + 9'h001;
		if (stateQ != ST_TOP)
			topMinD = 6'h00;
		else if (minTick && !sense.battTempFault && !topExpired)
			topMinD = topMinQ + 6'h01;
	end

	// Outputs follow the next state so they align with the state register
	lcsc_drive_t driveD;
	lcsc_stat_t statD;
	logic charging;

	assign charging = (stateD == ST_PQ) || (stateD == ST_CC) || (stateD == ST_CV) || (stateD == ST_TOP);

	always_comb
	begin
		driveD.systemRegulate = inputOk;
		// Invalid input keeps battery on system
		// Raw valid too, so a dropout connects with no lag
		driveD.batteryConnect = !sense.inputValid || !inputOk || charging;
		driveD.chargeCurrentOn = charging && !sense.battTempFault;
		driveD.prechargeMode = (stateD == ST_PQ);
		driveD.constVoltageMode = (stateD == ST_CV) || (stateD == ST_TOP);
		statD.chargerStateCode = state_code(stateD);
		statD.inputQualityCode = sense.inputQualityCode;
		statD.inputVoltageLoopActive = sense.inputVoltageLoop;
		statD.inputLimitActive = sense.inputLimitLoop;
		statD.systemLoopActive = sense.systemLoop;
		statD.dieTempLoopActive = sense.dieTempLoop;
		statD.fastTimerSuspended = fcSuspend;
		statD.inputDebounced = inputOk;
	end

	assign flagSet.inputControlIrq = (sense.inputVoltageLoop && !status.inputVoltageLoopActive)
		|| (sense.inputLimitLoop && !status.inputLimitActive);
	assign flagSet.systemLoopIrq = (sense.systemLoop != status.systemLoopActive);
	assign flagSet.dieTempIrq = (sense.dieTempLoop != status.dieTempLoopActive);
	assign flagSet.chargerStateIrq = (statD.chargerStateCode != status.chargerStateCode);
	assign flagSet.inputQualityIrq = (sense.inputQualityCode != status.inputQualityCode);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			cfgA <= `LCSC_CFG_A_RST;
			cfgB <= `LCSC_CFG_B_RST;
			cfgC <= `LCSC_CFG_C_RST;
			maskQ <= `LCSC_MASK_RST;
			flagsQ <= '0;
			regRdata <= 32'h0000_0000;
			debQ <= 7'h00;
			stateQ <= ST_OFF;
			pqMinQ <= 5'h00;
			fcMinQ <= 9'h000;
			topMinQ <= 6'h00;
			drive <= '0;
			status <= '0;
			inputLimitMa <= 9'h000;
			irq <= 1'b0;
		end
		else
		begin
			cfgA <= cfgAD;
			cfgB <= cfgBD;
			cfgC <= cfgCD;
			maskQ <= maskD;
			flagsQ <= flagsD;
			regRdata <= rdataD;
			debQ <= debD;
			stateQ <= stateD;
			pqMinQ <= pqMinD;
			fcMinQ <= fcMinD;
			topMinQ <= topMinD;
			drive <= driveD;
			status <= statD;
			inputLimitMa <= limit_ma(cfgAD.inputLimitSel, LIMIT_LOW_DEFAULT);
			irq <= |(flagsD & ~maskD);
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence sDoneRestart;
		stateQ == ST_DONE && sense.battBelowRestart && inputOk && cfgA.chargeEnableBit;
	endsequence

	sequence sPqTimeout;
		stateQ == ST_PQ && pqExpired && sense.battBelowPrechargeThreshold && inputOk && cfgA.chargeEnableBit;
	endsequence

	a_off_when_disabled: assert property (!cfgA.chargeEnableBit |=> stateQ == ST_OFF)
		else $error("charger not off while disabled");
	a_pq_timeout_fault: assert property (sPqTimeout |=> stateQ == ST_PQF ##0 !drive.chargeCurrentOn)
		else $error("prequal timeout did not fault");
	a_done_restart_cc: assert property (sDoneRestart |=> stateQ == ST_CC && status.chargerStateCode == `LCSC_CODE_CC)
		else $error("done did not restart constant current");
	a_limit_decode: assert property (1 |=> inputLimitMa == limit_ma($past(cfgAD.inputLimitSel), LIMIT_LOW_DEFAULT))
		else $error("input limit decode wrong");
	a_state_change_flag: assert property ($changed(status.chargerStateCode) |-> flagsQ.chargerStateIrq)
		else $error("state change not flagged");
	a_sys_loop_flag: assert property ($changed(status.systemLoopActive) |-> flagsQ.systemLoopIrq)
		else $error("system loop change not flagged");
	a_die_temp_flag: assert property ($changed(status.dieTempLoopActive) |-> flagsQ.dieTempIrq)
		else $error("die temperature change not flagged");
	a_vloop_engage_flag: assert property ($rose(status.inputVoltageLoopActive) |-> flagsQ.inputControlIrq)
		else $error("voltage loop engage not flagged");
	a_ilim_engage_flag: assert property ($rose(status.inputLimitActive) |-> flagsQ.inputControlIrq)
		else $error("limiter engage not flagged");
	a_invalid_connects: assert property (!sense.inputValid |=> drive.batteryConnect [*2])
		else $error("battery not connected on invalid input");
	a_fault_no_current: assert property (stateQ == ST_FCF |-> !drive.chargeCurrentOn && !drive.batteryConnect)
		else $error("current delivered in fast timer fault");

endmodule : lcsc_charger_ctrl
`default_nettype wire

// File: lcsc_analog_model.sv
/*
 Analog power path stand-in: turns bench-set battery millivolts and loop
 states into the registered sense struct. Assumes one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lcsc_analog_model
	import lcsc_pkg::*;
#(
	parameter int PQ_MV = 3000,
	parameter int REG_MV = 4200,
	parameter int RESTART_MV = 150
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire lcsc_drive_t drive,
	input wire logic inValid,
	input wire logic [12:0] battMv,
	input wire logic [1:0] qual,
	input wire logic term,
	input wire logic [6:0] loopSet,
	output lcsc_sense_t sense
);
	lcsc_sense_t senseD;
	always_comb
	begin
		senseD = '0;
		senseD.inputValid = inValid;
		senseD.inputQualityCode = qual;
		senseD.battBelowPrechargeThreshold = battMv < PQ_MV;
		senseD.battAtRegulation = battMv >= REG_MV;
		senseD.battBelowRestart = battMv < REG_MV - RESTART_MV;
		// Current only tapers while voltage is held
		senseD.currentBelowTerm = term && drive.constVoltageMode;
		{senseD.battTempFault, senseD.supplementMode, senseD.ccCurrentBelowFifth} = loopSet[6:4];
		{senseD.dieTempLoop, senseD.systemLoop, senseD.inputLimitLoop, senseD.inputVoltageLoop} = loopSet[3:0];
	end
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			sense <= '0;
		else
			sense <= senseD;
	end
endmodule : lcsc_analog_model
`default_nettype wire

// File: tb_lcsc.sv
/*
 Self-checking bench of the charger state control with scaled timers.
 Assumes minute = 12 cycles (MS_CYCLES 4, MS_PER_MIN 3).
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lcsc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] regAddr = '0;
	logic [31:0] regWdata = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdata;
	lcsc_sense_t sense;
	lcsc_drive_t drive;
	lcsc_stat_t status;
	logic irq;
	lcsc_cfg_a_t cfgA;
	lcsc_cfg_b_t cfgB;
	lcsc_cfg_c_t cfgC;
	logic [8:0] limMa;
	logic [8:0] limMaLow;
	logic inValid = 1'b0;
	logic [12:0] battMv = 13'd4150;
	logic [1:0] qual = '0;
	logic term = 1'b0;
	logic [6:0] loopSet = '0;
	int errTotal = 0;
	int nCompared = 0;
	int n;
	lcsc_charger_ctrl #(.MS_CYCLES(4), .MS_PER_MIN(3), .LIMIT_LOW_DEFAULT(1'b0)) i_dut (.clk_sys(clk_sys),
		.rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .sense(sense), .drive(drive), .cfgA(cfgA), .cfgB(cfgB), .cfgC(cfgC),
		.status(status), .inputLimitMa(limMa), .irq(irq));
	// Mirrored limit table variant shares bus and sense
	lcsc_charger_ctrl #(.MS_CYCLES(4), .MS_PER_MIN(3), .LIMIT_LOW_DEFAULT(1'b1)) i_dut_low (.clk_sys(clk_sys),
		.rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(), .sense(sense), .drive(), .cfgA(), .cfgB(), .cfgC(), .status(),
		.inputLimitMa(limMaLow), .irq());
	lcsc_analog_model i_model (.clk_sys(clk_sys), .rst_b(rst_b), .drive(drive), .inValid(inValid),
		.battMv(battMv), .qual(qual), .term(term), .loopSet(loopSet), .sense(sense));
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp)
		begin
			errTotal++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		chk(regRdata, exp);
	endtask : rd
	task automatic wait_code(input logic [3:0] c, input int lim, output int cnt);
		cnt = 0;
		while (status.chargerStateCode !== c && cnt < lim)
		begin
			cyc(1);
			cnt++;
		end
		chk(status.chargerStateCode, c);
	endtask : wait_code
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errTotal++;
		report_and_stop();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(4'h0, 32'h3);
		rd(4'h1, 32'h5000);
		rd(4'h5, 32'h1f);
		rd(4'h6, 32'd475);
		chk(cfgA, 32'h3);
		chk(cfgB, 32'h5000);
		chk(cfgC, 32'h0);
		rd(4'h7, 32'h0);
		wr(4'h3, 32'hffff);
		rd(4'h3, 32'h0);
		chk(drive.batteryConnect, 1'b1);
		wr(4'h1, 32'h1ffff);
		rd(4'h1, 32'h1ffff);
		chk(cfgB, 32'h1ffff);
		wr(4'h2, 32'hffffffff);
		rd(4'h2, 32'h1ff);
		chk(cfgC, 32'h1ff);
		wr(4'h1, 32'h5000);
		for (int i = 0; i < 8; i++)
		begin
			wr(4'h0, (i << 2) | 3);
			cyc(2);
			rd(4'h6, (i >= 4) ? 32'd95 : 32'd475 - 32'd95 * i);
			chk(limMa, (i >= 4) ? 32'd95 : 32'd475 - 32'd95 * i);
			chk(limMaLow, (i >= 4) ? 32'd475 : 32'd95 + 32'd95 * i);
		end
		wr(4'h0, 32'h3);
		// Loop bits: engage flags input-control, the others flag both ways
		wr(4'h5, 32'h0);
		for (int b = 0; b < 4; b++)
		begin
			wr(4'h4, 32'h1f);
			loopSet[b] <= 1'b1;
			cyc(3);
			chk(status[6 + b], 1'b1);
			chk(irq, 1'b1);
			rd(4'h4, 32'h1 << ((b == 0) ? 0 : b - 1));
			wr(4'h4, 32'h1f);
			cyc(1);
			chk(irq, 1'b0);
			loopSet[b] <= 1'b0;
			cyc(3);
			chk(status[6 + b], 1'b0);
			rd(4'h4, (b < 2) ? 32'h0 : 32'h1 << (b - 1));
		end
		wr(4'h4, 32'h1f);
		qual <= 2'd1;
		cyc(3);
		rd(4'h4, 32'h10);
		wr(4'h4, 32'h1f);
		wr(4'h5, 32'h1f);
		loopSet[2] <= 1'b1;
		cyc(3);
		chk(irq, 1'b0);
		rd(4'h4, 32'h2);
		loopSet[2] <= 1'b0;
		inValid <= 1'b1;
		cyc(470);
		chk({drive.systemRegulate, status.inputDebounced}, 2'b00);
		cyc(50);
		chk({drive.systemRegulate, status.inputDebounced}, 2'b11);
		chk(status.chargerStateCode, 4'h0);
		chk(drive.batteryConnect, 1'b0);
		wr(4'h4, 32'h1f);
		battMv <= 13'd2500;
		wait_code(4'h1, 5, n);
		chk({drive.chargeCurrentOn, drive.prechargeMode}, 2'b11);
		rd(4'h4, 32'h8);
		wait_code(4'h6, 450, n);
		chk(n >= 340 && n <= 380, 1'b1);
		chk({drive.chargeCurrentOn, drive.batteryConnect}, 2'b00);
		// Replug input to leave the fault
		inValid <= 1'b0;
		wait_code(4'h0, 5, n);
		chk(drive.batteryConnect, 1'b1);
		inValid <= 1'b1;
		battMv <= 13'd3500;
		wait_code(4'h2, 600, n);
		loopSet[4] <= 1'b1;
		cyc(3);
		chk(status.fastTimerSuspended, 1'b1);
		cyc(240);
		loopSet[4] <= 1'b0;
		wait_code(4'h7, 2600, n);
		chk(n >= 2124 && n <= 2184, 1'b1);
		chk({drive.chargeCurrentOn, drive.batteryConnect}, 2'b00);
		// Enable toggle clears the fault
		wr(4'h0, 32'h2);
		wr(4'h0, 32'h3);
		wait_code(4'h2, 10, n);
		battMv <= 13'd4200;
		wait_code(4'h3, 5, n);
		chk(drive.constVoltageMode, 1'b1);
		term <= 1'b1;
		wait_code(4'h4, 5, n);
		wait_code(4'h5, 100, n);
		chk(n >= 46 && n <= 74, 1'b1);
		chk(drive.batteryConnect, 1'b0);
		term <= 1'b0;
		wr(4'h0, 32'h1);
		battMv <= 13'd4100;
		cyc(20);
		chk(status.chargerStateCode, 4'h5);
		battMv <= 13'd4000;
		wait_code(4'h2, 5, n);
		wr(4'h0, 32'h0);
		cyc(2);
		chk(status.chargerStateCode, 4'h0);
		battMv <= 13'd4100;
		wr(4'h0, 32'h1);
		wait_code(4'h2, 10, n);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
